// >>> common/out_clk_pkg.sv
// shared constants and types for the output clock divider chain
package out_clk_pkg;
    // =====================================================
    // output format codes
    localparam logic [3:0] FMT_DISABLED = 4'h0;
    localparam logic [3:0] FMT_LVDS = 4'h1;
    localparam logic [3:0] FMT_PROG_DIFF = 4'h2;
    localparam logic [3:0] FMT_HCSL = 4'h3;
    localparam logic [3:0] FMT_HSTL = 4'h4;
    localparam logic [3:0] FMT_CMOS_P_ONLY = 4'h5;
    localparam logic [3:0] FMT_CMOS_IN_PHASE = 4'h6;
    localparam logic [3:0] FMT_CMOS_INVERTED = 4'h7;
    // =====================================================
    // field widths and reset values
    localparam int MS_W = 7;
    localparam int LS_W = 24;
    localparam int DC_W = 8;
    localparam int PH_W = 4;
    localparam logic [3:0] FIXED_LVDS_SWING = 4'h0;
    localparam logic [LS_W-1:0] LS_RESET = 24'h000000;
    localparam logic [MS_W-1:0] MS_RESET = 7'h00;
    // =====================================================
    // driver mode
    typedef enum logic [4:0] {
        DRV_OFF = 5'b00001,
        DRV_LVDS = 5'b00010,
        DRV_DIFF = 5'b00100,
        DRV_HCSL = 5'b01000,
        DRV_SE = 5'b10000
    } drv_mode_t;
    typedef struct packed {
        logic [3:0] format_select;
        logic output_invert;
        logic [1:0] drive_strength;
        logic [3:0] diff_swing_setting;
        logic [3:0] common_mode_setting;
    } out_cfg_t;
    typedef struct packed {
        drv_mode_t mode;
        logic low_power;
        logic [1:0] drive_strength;
        logic [3:0] swing;
        logic [3:0] common_mode;
    } drv_ctl_t;
endpackage : out_clk_pkg

// >>> rtl/ms_divider.sv
// medium-speed divider with 50% duty on even ratios, used as an enable generator
`timescale 1ns/1ps
module ms_divider #(
    parameter int W = 7
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic en,
    input wire logic [W-1:0] div_value,
    output logic tick,
    output logic half_tick,
    output logic level
);
    // =====================================================
    // counter
    logic [W-1:0] cnt_reg;
    logic [W:0] ratio;
    assign ratio = {1'b0, div_value} + {{W{1'b0}}, 1'b1};
    always_ff @(posedge clk) begin
        if (!rst_n || clr) begin
            cnt_reg <= '0;
        end else if (en && cnt_reg >= div_value) begin
            cnt_reg <= '0;
        end else if (en) begin
            // holding between enables keeps the ratio in source periods, not in clk cycles
            cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
        end
    end
    // rising at count 0, falling at half the ratio; odd ratios lose half a cycle of
    // accuracy here because the chain runs on one edge only
    assign tick = (cnt_reg == '0);
    assign half_tick = ({1'b0, cnt_reg} == (ratio >> 1));
    always_ff @(posedge clk) begin
        if (!rst_n || clr) begin
            level <= 1'b0;
        end else if (en && cnt_reg >= div_value) begin
            level <= 1'b1;
        end else if (en && ({1'b0, cnt_reg} + {{W{1'b0}}, 1'b1} == (ratio >> 1))) begin
            level <= 1'b0;
        end
    end
endmodule : ms_divider

// >>> rtl/output_clock_divider_chain.sv
// per-output clock divider chain: source mux, dividers, duty, phase, format and align
// =====================================================
// Notes on behaviour
// - disabled format tri-states both pins and puts the driver in low power
// - format 0001 is fixed low-swing differential, 0010 programmable differential
// - in 0001 the swing setting is ignored, common mode still passes
// - invert bit flips the clock into the driver, a half-cycle shift
// - cmos and hstl pass one of four drive strengths
// - cmos negative pin is off, in phase or inverted per format code; dual mode does not invert it
// - each bank picks integer or fractional tap of either pll
// - medium divider of 7 bits then low divider of 24 bits in series
// - medium divider gives 50% duty on even ratios only; low divider gives 50% unless duty adjust is active
// - low divider usable only when medium value is nonzero; zero bypasses
// - dual mode: positive pin medium only, negative pin low divided by value plus one
// - duty adjust only with medium value above 0 and low value above 1
// - pulse width 0 gives 50%, else that many medium periods high
// - invert 0 makes the pulse high, invert 1 makes it low
// - duty adjust sits in the low divider; in dual mode only negative pin
// - phase offset counts whole source clock periods
// - rising align trigger resets both dividers of participating outputs
// - participating outputs from one tap rise together, offset by phase
`timescale 1ns/1ps
module output_clock_divider_chain
    import out_clk_pkg::*;
#(
    parameter int MSW = out_clk_pkg::MS_W,
    parameter int LSW = out_clk_pkg::LS_W,
    parameter int PHW = out_clk_pkg::PH_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] tap_enables,
    input wire logic [1:0] bank_source_mux,
    input wire logic divider_enable_mask,
    input wire out_clk_pkg::out_cfg_t out_cfg,
    input wire logic [MSW-1:0] medium_divide_value,
    input wire logic [LSW-1:0] low_divide_value,
    input wire logic low_divider_path_select,
    input wire logic neg_pin_low_divider_select,
    input wire logic [7:0] pulse_width_setting,
    input wire logic signed [PHW-1:0] phase_offset_setting,
    input wire logic align_participate,
    input wire logic pll1_align_trigger,
    input wire logic pll2_align_trigger,
    output logic positive_out_pin_o,
    output logic positive_out_pin_oe,
    output logic negative_out_pin_o,
    output logic negative_out_pin_oe,
    output out_clk_pkg::drv_ctl_t drv_ctl
);
    import out_clk_pkg::*;
    // =====================================================
    // source tap enable and alignment trigger
    logic src_en;
    logic trig_sel;
    logic [1:0] trig_sync_reg;
    logic trig_prev_reg;
    logic align_pulse;
    logic chain_clr;
    assign src_en = tap_enables[bank_source_mux];
    // bank_source_mux[1] picks the pll; the trigger arrives from another block, synced here
    assign trig_sel = bank_source_mux[1] ? pll2_align_trigger : pll1_align_trigger;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_sync_reg <= 2'b00;
            trig_prev_reg <= 1'b0;
        end else begin
            trig_sync_reg <= {trig_sync_reg[0], trig_sel};
            trig_prev_reg <= trig_sync_reg[1];
        end
    end
    assign align_pulse = trig_sync_reg[1] && !trig_prev_reg && align_participate;
    assign chain_clr = align_pulse || !divider_enable_mask;
    // =====================================================
    // phase offset: hold the chain in reset for a number of source periods after align
    logic [PHW:0] hold_reg;
    logic holding;
    function automatic logic [PHW:0] hold_count(input logic signed [PHW-1:0] ph);
        logic [PHW:0] bias;
        bias = {1'b1, {PHW{1'b0}}} >> 1;
        hold_count = bias + {ph[PHW-1], ph};
    endfunction : hold_count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_reg <= '0;
        end else if (chain_clr) begin
            // signed offset biased around mid-range so both advance and delay exist
            hold_reg <= hold_count(phase_offset_setting);
        end else if (src_en && hold_reg != '0) begin
            hold_reg <= hold_reg - {{PHW{1'b0}}, 1'b1};
        end
    end
    assign holding = (hold_reg != '0);
    // =====================================================
    // medium-speed divider
    logic ms_tick;
    logic ms_level;
    logic ms_clr;
    logic [MSW-1:0] ms_val;
    assign ms_clr = chain_clr || holding;
    assign ms_val = medium_divide_value;
    // the divider advances only on source enables, so one count equals one source period
    ms_divider #(
        .W(MSW)
    ) u_ms (
        .clk(clk),
        .rst_n(rst_n),
        .clr(ms_clr),
        .en(src_en),
        .div_value(ms_val),
        .tick(ms_tick),
        .half_tick(),
        .level(ms_level)
    );
    // =====================================================
    // low-speed divider with duty adjustment
    logic [LSW:0] ls_cnt_reg;
    logic [LSW:0] ls_ratio;
    logic ls_level_reg;
    logic duty_active;
    logic ms_rise_reg;
    logic ms_edge;
    assign ls_ratio = {1'b0, low_divide_value} + {{LSW{1'b0}}, 1'b1};
    // duty adjust needs both dividers engaged with enough low-speed cycles
    assign duty_active = (pulse_width_setting != 8'h00) && (ms_val != '0)
        && (low_divide_value > 24'h000001);
    always_ff @(posedge clk) begin
        if (!rst_n || ms_clr) begin
            ms_rise_reg <= 1'b0;
        end else begin
            ms_rise_reg <= ms_level;
        end
    end
    assign ms_edge = ms_level && !ms_rise_reg;
    always_ff @(posedge clk) begin
        if (!rst_n || ms_clr) begin
            ls_cnt_reg <= '0;
        end else if (ms_edge) begin
            if (ls_cnt_reg + {{LSW{1'b0}}, 1'b1} >= ls_ratio) begin
                ls_cnt_reg <= '0;
            end else begin
                ls_cnt_reg <= ls_cnt_reg + {{LSW{1'b0}}, 1'b1};
            end
        end
    end
    // low output toggles over whole medium periods; odd ratios split on medium halves
    always_ff @(posedge clk) begin
        if (!rst_n || ms_clr) begin
            ls_level_reg <= 1'b0;
        end else if (duty_active) begin
            ls_level_reg <= (ls_cnt_reg < {{(LSW-7){1'b0}}, pulse_width_setting});
        end else if (ls_ratio[0]) begin
            ls_level_reg <= (({ls_cnt_reg, ms_level}) < ls_ratio);
        end else begin
            ls_level_reg <= (ls_cnt_reg < (ls_ratio >> 1));
        end
    end
    // =====================================================
    // path selection, dual frequency and polarity
    logic pos_clk;
    logic neg_clk;
    logic ls_used;
    logic dual_mode;
    logic is_cmos;
    assign is_cmos = (out_cfg.format_select == FMT_CMOS_P_ONLY) || (out_cfg.format_select == FMT_CMOS_IN_PHASE)
        || (out_cfg.format_select == FMT_CMOS_INVERTED);
    assign ls_used = low_divider_path_select && (ms_val != '0);
    assign dual_mode = is_cmos && !low_divider_path_select && neg_pin_low_divider_select;
    // zero medium value passes the source enable straight through
    assign pos_clk = (ms_val == '0) ? src_en : (ls_used ? ls_level_reg : ms_level);
    assign neg_clk = dual_mode ? ls_level_reg : pos_clk;
    // =====================================================
    // output pins and driver control, all registered
    logic p_next;
    logic n_next;
    logic p_oe_next;
    logic n_oe_next;
    logic driving;
    assign driving = (out_cfg.format_select != FMT_DISABLED) && divider_enable_mask;
    always_comb begin
        p_next = pos_clk ^ out_cfg.output_invert;
        n_next = neg_clk ^ out_cfg.output_invert;
        p_oe_next = driving;
        n_oe_next = driving;
        case (out_cfg.format_select)
            FMT_CMOS_P_ONLY: begin
                n_oe_next = 1'b0;
            end
            FMT_CMOS_IN_PHASE: begin
                n_next = neg_clk ^ out_cfg.output_invert;
            end
            FMT_CMOS_INVERTED: begin
                n_next = dual_mode ? n_next : !n_next;
            end
            FMT_DISABLED: begin
                p_oe_next = 1'b0;
                n_oe_next = 1'b0;
            end
            default: begin
                n_next = !p_next;
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            positive_out_pin_o <= 1'b0;
            negative_out_pin_o <= 1'b0;
            positive_out_pin_oe <= 1'b0;
            negative_out_pin_oe <= 1'b0;
        end else begin
            positive_out_pin_o <= p_next;
            negative_out_pin_o <= n_next;
            positive_out_pin_oe <= p_oe_next;
            negative_out_pin_oe <= n_oe_next;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drv_ctl <= '{mode: DRV_OFF, low_power: 1'b1, drive_strength: 2'b00, swing: 4'h0, common_mode: 4'h0};
        end else begin
            drv_ctl.low_power <= (out_cfg.format_select == FMT_DISABLED);
            drv_ctl.common_mode <= out_cfg.common_mode_setting;
            drv_ctl.swing <= (out_cfg.format_select == FMT_LVDS) ? FIXED_LVDS_SWING
                : out_cfg.diff_swing_setting;
            drv_ctl.drive_strength <= (is_cmos || out_cfg.format_select == FMT_HSTL)
                ? out_cfg.drive_strength : 2'b00;
            case (out_cfg.format_select)
                FMT_DISABLED: drv_ctl.mode <= DRV_OFF;
                FMT_LVDS: drv_ctl.mode <= DRV_LVDS;
                FMT_PROG_DIFF: drv_ctl.mode <= DRV_DIFF;
                FMT_HCSL: drv_ctl.mode <= DRV_HCSL;
                default: drv_ctl.mode <= DRV_SE;
            endcase
        end
    end
    // =====================================================
    // checks
    a_disabled_tristate: assert property (@(posedge clk) disable iff (!rst_n)
        (out_cfg.format_select == FMT_DISABLED) |=> !positive_out_pin_oe && !negative_out_pin_oe)
        else $error("disabled output still driven");
    a_lvds_fixed_swing: assert property (@(posedge clk) disable iff (!rst_n)
        (out_cfg.format_select == FMT_LVDS) |=> drv_ctl.swing == FIXED_LVDS_SWING)
        else $error("lvds swing not fixed");
    a_align_clears: assert property (@(posedge clk) disable iff (!rst_n)
        align_pulse |=> hold_reg == hold_count($past(phase_offset_setting)))
        else $error("align did not load phase hold");
    a_invert_output: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> positive_out_pin_o == ($past(pos_clk) ^ $past(out_cfg.output_invert)))
        else $error("invert not applied");
    a_cmos_p_only: assert property (@(posedge clk) disable iff (!rst_n)
        (out_cfg.format_select == FMT_CMOS_P_ONLY) |=> !negative_out_pin_oe)
        else $error("negative pin driven in p-only mode");
    a_mode_decode: assert property (@(posedge clk) disable iff (!rst_n)
        (out_cfg.format_select == FMT_PROG_DIFF) |=> drv_ctl.mode == DRV_DIFF)
        else $error("programmable differential not decoded");
    a_ms_bypass: assert property (@(posedge clk) disable iff (!rst_n)
        (ms_val == '0) |-> pos_clk == src_en)
        else $error("zero medium value not bypassed");
    a_drive_strength: assert property (@(posedge clk) disable iff (!rst_n)
        (out_cfg.format_select == FMT_HSTL) |=> drv_ctl.drive_strength == $past(out_cfg.drive_strength))
        else $error("drive strength not passed");
    a_cmos_drive: assert property (@(posedge clk) disable iff (!rst_n)
        is_cmos |=> drv_ctl.drive_strength == $past(out_cfg.drive_strength))
        else $error("cmos drive strength not passed");
    a_prog_swing: assert property (@(posedge clk) disable iff (!rst_n)
        (out_cfg.format_select == FMT_PROG_DIFF) |=> drv_ctl.swing == $past(out_cfg.diff_swing_setting))
        else $error("programmable swing not passed");
    a_lvds_common: assert property (@(posedge clk) disable iff (!rst_n)
        (out_cfg.format_select == FMT_LVDS) |=> drv_ctl.common_mode == $past(out_cfg.common_mode_setting))
        else $error("lvds common mode not passed");
    a_low_power_off: assert property (@(posedge clk) disable iff (!rst_n)
        (out_cfg.format_select == FMT_DISABLED) |=> drv_ctl.low_power)
        else $error("disabled driver not in low power");
    a_mask_tristate: assert property (@(posedge clk) disable iff (!rst_n)
        !divider_enable_mask |=> !positive_out_pin_oe && !negative_out_pin_oe)
        else $error("output driven with divider mask clear");
    a_cmos_in_phase: assert property (@(posedge clk) disable iff (!rst_n)
        (out_cfg.format_select == FMT_CMOS_IN_PHASE && !dual_mode) |=> negative_out_pin_o == positive_out_pin_o)
        else $error("negative pin not in phase");
    a_cmos_inverted: assert property (@(posedge clk) disable iff (!rst_n)
        (out_cfg.format_select == FMT_CMOS_INVERTED && !dual_mode) |=> negative_out_pin_o != positive_out_pin_o)
        else $error("negative pin not inverted");
    a_dual_pos_medium: assert property (@(posedge clk) disable iff (!rst_n)
        (dual_mode && ms_val != '0) |-> pos_clk == ms_level)
        else $error("dual mode positive pin not from medium divider");
    a_ms_rise_tick: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(ms_level) |-> ms_tick)
        else $error("medium clock rose away from count zero");
    a_clr_zeroes: assert property (@(posedge clk) disable iff (!rst_n)
        ms_clr |=> !ms_level && ls_cnt_reg == '0)
        else $error("dividers not cleared");
    a_align_single: assert property (@(posedge clk) disable iff (!rst_n)
        align_pulse |=> !align_pulse)
        else $error("align pulse longer than one cycle");
    a_pw_zero_half: assert property (@(posedge clk) disable iff (!rst_n)
        (pulse_width_setting == 8'h00) |-> !duty_active)
        else $error("duty adjust active with zero pulse width");
endmodule : output_clock_divider_chain

// >>> dv/clk_rx_model.sv
// receiving end of one output clock pin: resolves the wire and times its edges
`timescale 1ns/1ps
module clk_rx_model (
    input wire logic clk,
    input wire logic clear,
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic level,
    output int period = 0,
    output int high_time = 0,
    output int rise_at = 0
);
    // =====================================================
    // wire level and edge timing
    logic last_reg = 1'b0;
    int cyc_reg = 0;
    // no pull on the line: a released pin toggles, so a stale level cannot pass for a clock
    assign level = pin_oe ? pin_o : ~last_reg;
    always @(posedge clk) begin
        cyc_reg <= cyc_reg + 1;
        last_reg <= level;
        if (clear) begin
            period <= 0;
            high_time <= 0;
        end else if (level && !last_reg) begin
            period <= cyc_reg - rise_at;
            rise_at <= cyc_reg;
        end else if (!level && last_reg) begin
            high_time <= cyc_reg - rise_at;
        end
    end
endmodule : clk_rx_model

// >>> dv/testbench.sv
// self-checking bench for the output clock divider chain
`timescale 1ns/1ps
module testbench;
    import out_clk_pkg::*;
    // =====================================================
    // stimulus and observation
    typedef struct {
        int ms, ls, lssel, neg, pw, inv, pp, ph, np, nh;
    } row_t;
    // ms ls lssel neg pw inv | p period, p high, n period, n high (fmt: cmos n in phase)
    row_t rows[10] = '{
        '{1, 0, 0, 0, 0, 0, 2, 1, 2, 1},
        '{2, 0, 0, 0, 0, 0, 3, 1, 3, 1},
        '{1, 4, 1, 0, 0, 0, 10, 5, 10, 5},
        '{1, 4, 1, 0, 3, 0, 10, 6, 10, 6},
        '{1, 4, 1, 0, 3, 1, 10, 4, 10, 4},
        '{1, 1, 1, 0, 3, 0, 4, 2, 4, 2},
        '{2, 2, 1, 0, 0, 0, 9, 4, 9, 4},
        '{1, 3, 0, 1, 0, 0, 2, 1, 8, 4},
        '{1, 3, 0, 1, 3, 0, 2, 1, 8, 6},
        '{1, 4, 0, 0, 3, 0, 2, 1, 2, 1}
    };
    int ph_tab[3] = '{3, -3, 0};
    int gap_tab[3] = '{3, 7, 5};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] tap_enables = 4'hf;
    logic [1:0] mux = 2'h0;
    logic mask = 1'b0;
    out_cfg_t cfg = '0;
    out_cfg_t cfg_b = '0;
    logic [6:0] ms = 7'h01;
    logic [23:0] ls = 24'h000000;
    logic lssel = 1'b0;
    logic neg = 1'b0;
    logic [7:0] pw = 8'h00;
    logic signed [3:0] ph_a = 4'h0;
    logic signed [3:0] ph_b = 4'h0;
    logic part = 1'b1;
    logic trig1 = 1'b0;
    logic trig2 = 1'b0;
    logic clr = 1'b0;
    logic tap_slow = 1'b0;
    logic tap_tog = 1'b0;
    logic p_o, p_oe, n_o, n_oe, bp_o, bp_oe, lv_p, lv_n, lv_b;
    drv_ctl_t drv;
    int pp, ph, np, nh, ra, rb;
    int err_total = 0;
    int check_count = 0;
    drv_mode_t modes[4] = '{DRV_OFF, DRV_LVDS, DRV_DIFF, DRV_HCSL};
    output_clock_divider_chain dut (
        .clk(clk), .rst_n(rst_n), .tap_enables(tap_enables), .bank_source_mux(mux), .divider_enable_mask(mask),
        .out_cfg(cfg), .medium_divide_value(ms), .low_divide_value(ls), .low_divider_path_select(lssel),
        .neg_pin_low_divider_select(neg), .pulse_width_setting(pw), .phase_offset_setting(ph_a),
        .align_participate(part), .pll1_align_trigger(trig1), .pll2_align_trigger(trig2),
        .positive_out_pin_o(p_o), .positive_out_pin_oe(p_oe), .negative_out_pin_o(n_o),
        .negative_out_pin_oe(n_oe), .drv_ctl(drv));
    output_clock_divider_chain dut_b (
        .clk(clk), .rst_n(rst_n), .tap_enables(tap_enables), .bank_source_mux(mux), .divider_enable_mask(mask),
        .out_cfg(cfg_b), .medium_divide_value(ms), .low_divide_value(ls), .low_divider_path_select(lssel),
        .neg_pin_low_divider_select(neg), .pulse_width_setting(pw), .phase_offset_setting(ph_b),
        .align_participate(part), .pll1_align_trigger(trig1), .pll2_align_trigger(trig2),
        .positive_out_pin_o(bp_o), .positive_out_pin_oe(bp_oe), .negative_out_pin_o(),
        .negative_out_pin_oe(), .drv_ctl());
    clk_rx_model rx_p (.clk(clk), .clear(clr), .pin_o(p_o), .pin_oe(p_oe), .level(lv_p), .period(pp),
        .high_time(ph), .rise_at(ra));
    clk_rx_model rx_n (.clk(clk), .clear(clr), .pin_o(n_o), .pin_oe(n_oe), .level(lv_n), .period(np),
        .high_time(nh), .rise_at());
    clk_rx_model rx_b (.clk(clk), .clear(clr), .pin_o(bp_o), .pin_oe(bp_oe), .level(lv_b), .period(),
        .high_time(), .rise_at(rb));
    // =====================================================
    // clock, slow tap and helpers
    always #12.5 clk = ~clk;
    // the selected tap pulses every other cycle, the rest every cycle, so a wrong pick shows as a wrong period
    // taps stand in for the pll outputs; external feedback setup stays with the pll
    always @(posedge clk) begin
        tap_tog <= ~tap_tog;
        tap_enables <= (tap_slow && tap_tog) ? ~(4'h1 << mux) : 4'hf;
    end
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask : cycles
    task automatic check_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit
    task automatic check_vec(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check_vec
    // odd ratios may land the high time on either side of the half period
    task automatic check_near(input string what, input int exp, input int got, input int tol);
        check_count++;
        if (got < exp || got > exp + tol) begin
            err_total++;
            $display("unexpected %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_near
    task automatic reset_check();
        @(negedge clk);
        check_bit("p_oe", 1'b0, p_oe);
        check_bit("n_oe", 1'b0, n_oe);
        check_bit("low_power", 1'b1, drv.low_power);
        check_vec("mode", 8'(DRV_OFF), 8'(drv.mode));
    endtask : reset_check
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    initial begin
        cycles(6000);
        err_total++;
        close_out();
    end
    // =====================================================
    // main sequence
    initial begin
        cycles(4);
        reset_check();
        @(posedge clk);
        rst_n <= 1'b1;
        mask <= 1'b1;
        cfg_b.format_select <= FMT_CMOS_IN_PHASE;
        cfg.diff_swing_setting <= 4'h9;
        cfg.common_mode_setting <= 4'h5;
        for (int f = 0; f < 8; f++) begin
            @(posedge clk);
            cfg.format_select <= 4'(f);
            cfg.drive_strength <= 2'(f);
            cycles(3);
            @(negedge clk);
            check_bit("p_oe", f != 0, p_oe);
            check_bit("n_oe", f != 0 && f != 5, n_oe);
            check_bit("low_power", f == 0, drv.low_power);
            if (f < 4) check_vec("mode", 8'(modes[f]), 8'(drv.mode));
            if (f == 1) check_vec("swing", 8'(FIXED_LVDS_SWING), 8'(drv.swing));
            if (f == 2) check_vec("swing", 8'h09, 8'(drv.swing));
            if (f == 1) check_vec("common_mode", 8'h05, 8'(drv.common_mode));
            if (f >= 4) check_vec("drive", 8'(f % 4), 8'(drv.drive_strength));
        end
        for (int f = 6; f < 8; f++) begin
            @(posedge clk);
            cfg.format_select <= 4'(f);
            cycles(3);
            repeat (6) begin
                @(negedge clk);
                check_bit("n_pin", p_o ^ (f == 7), n_o);
            end
        end
        foreach (rows[i]) begin
            @(posedge clk);
            mask <= 1'b0;
            clr <= 1'b1;
            cfg.format_select <= FMT_CMOS_IN_PHASE;
            cfg.output_invert <= rows[i].inv[0];
            ms <= 7'(rows[i].ms);
            ls <= 24'(rows[i].ls);
            lssel <= rows[i].lssel[0];
            neg <= rows[i].neg[0];
            pw <= 8'(rows[i].pw);
            cycles(2);
            mask <= 1'b1;
            clr <= 1'b0;
            cycles(70);
            @(negedge clk);
            check_near("p_period", rows[i].pp, pp, 0);
            check_near("p_high", rows[i].ph, ph, rows[i].pp % 2);
            check_near("n_period", rows[i].np, np, 0);
            check_near("n_high", rows[i].nh, nh, rows[i].np % 2);
        end
        @(posedge clk);
        tap_slow <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            mux <= 2'(m);
            cycles(30);
            @(negedge clk);
            check_near("mux_period", 4, pp, 0);
        end
        @(posedge clk);
        ms <= 7'h00;
        cycles(20);
        @(negedge clk);
        check_near("bypass_period", 2, pp, 0);
        @(posedge clk);
        tap_slow <= 1'b0;
        mux <= 2'h0;
        ms <= 7'h09;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            trig1 <= 1'b0;
            trig2 <= 1'b0;
            mux <= (k == 2) ? 2'h2 : 2'h0;
            ph_b <= 4'(ph_tab[k]);
            cfg_b.output_invert <= (k == 2);
            cycles(4);
            trig1 <= (k != 2);
            trig2 <= (k == 2);
            cycles(60);
            @(negedge clk);
            check_near("align_gap", gap_tab[k], ((rb - ra) % 10 + 10) % 10, 0);
        end
        @(posedge clk);
        rst_n <= 1'b0;
        cycles(2);
        reset_check();
        close_out();
    end
endmodule : testbench
